// File: lss_pkg.sv
// Package for the serial on/off LED sink link: widths and timing constants.
// Assumes a single 200 MHz system clock on both ends.
package lss_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned CHANNELS     = 16;
  localparam int unsigned FIFO_WIDTH   = 16;
  localparam int unsigned FIFO_DEPTH   = 4;
  // ==========================================================================
  // Timing
  localparam int unsigned SYS_CLK_PS   = 5000;
  localparam int unsigned LINK_HALF_NS = 60;
  localparam int unsigned LINK_HALF_CYC = (LINK_HALF_NS * 1000) / SYS_CLK_PS;
  localparam int unsigned STROBE_GAP_NS  = 100;
  localparam int unsigned STROBE_GAP_CYC = (STROBE_GAP_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
  localparam logic [7:0]  HALF_LAST    = 8'(LINK_HALF_CYC - 1);
  localparam logic [7:0]  GAP_LAST     = 8'(STROBE_GAP_CYC - 1);
  // Reset seed of the free-running test pattern that a latch strobe loads into the shift register
  localparam logic [15:0] TEST_SEED    = 16'h5a3c;
  // ==========================================================================
  // Host sequencer states
  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_LOW  = 5'h02,
    HS_HIGH = 5'h04,
    HS_STROBE = 5'h08,
    HS_GAP  = 5'h10
  } lss_host_state_t;
endpackage

// File: lss_link_if.sv
// Link interface between the controller end and the LED sink end.
// Assumes both ends share sys_clk; link pins are still sampled as foreign.
`timescale 1ns/1ps
`default_nettype none
interface lss_link_if;
  logic serial_data_in;
  logic shift_clk;
  logic latch_strobe;
  logic blank;
  logic serial_data_out;
  modport host (output serial_data_in, output shift_clk, output latch_strobe,
                output blank, input serial_data_out);
  modport dev  (input serial_data_in, input shift_clk, input latch_strobe,
                input blank, output serial_data_out);
endinterface
`default_nettype wire

// File: lss_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lss_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  // ==========================================================================
  // Storage and pointers
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH)); // Full stalls the source
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Data array needs no reset
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointer and occupancy bookkeeping
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: lss_device.sv
// LED sink end: 16-bit on/off shift register, latch, blanking and outputs.
// Assumes link pins come from another domain; each passes two flip-flops.
// Notes on behaviour
// (RULE_01) Separate shift register and latch; latch drives outputs
// (RULE_02) Shift clock rise loads data into LSB
// (RULE_03) Shift clock rise moves bits toward MSB
// (RULE_04) Serial output shows the shift register MSB
// (RULE_05) Serial output changes only on shift rise
// (RULE_06) Latch strobe rise copies register into latch
// (RULE_07) Latch strobe rise fills register with test data
// (RULE_08) Controller strobes latch once per full update
// (RULE_09) Unblanked output sinks when its latch bit is one
// (RULE_10) Blanking high forces every output off
// (RULE_11) No reset value for register or latch
// (RULE_12) Controller loads latch before enabling outputs
// (RULE_13) Controller holds blanking high at power-up
// (RULE_14) Controller zeroes bits of unconnected outputs; lss_host leaves that to the user in frame_data
// (RULE_15) All outputs switch together in one edge
// (RULE_16) Latch bit n drives output channel n
`timescale 1ns/1ps
`default_nettype none
module lss_device
  import lss_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                rst,
  lss_link_if.dev                  link,
  output logic [CHANNELS-1:0]      sink_output_n,
  output logic [CHANNELS-1:0]      latch_view
);
  // ==========================================================================
  // Pin synchronisers
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic       sclk_prev_ff;
  logic       strb_prev_ff;
  logic       sclk_rise;
  logic       strb_rise;

  // Two flops per pin; only the second stage feeds logic
  always_ff @(posedge sys_clk) begin
    meta_ff <= {link.blank, link.latch_strobe, link.shift_clk, link.serial_data_in};
    sync_ff <= meta_ff;
  end

  // Edge history of the synchronised clocks
  always_ff @(posedge sys_clk) begin
    sclk_prev_ff <= sync_ff[1];
    strb_prev_ff <= sync_ff[2];
  end

  assign sclk_rise = sync_ff[1] && !sclk_prev_ff;
  assign strb_rise = sync_ff[2] && !strb_prev_ff;

  // ==========================================================================
  // Shift register and latch; rst leaves both untouched, as in the part
  logic [CHANNELS-1:0] shift_ff;
  logic [CHANNELS-1:0] latch_ff;
  logic [CHANNELS-1:0] test_ff;
  logic                sdo_ff;

  // Free-running test pattern standing in for undefined reserved data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      test_ff <= TEST_SEED;
    end else begin
      test_ff <= {test_ff[14:0], test_ff[15] ^ test_ff[13] ^ test_ff[12] ^ test_ff[10]};
    end
  end

  // Strobe wins over a coincident shift edge; controller keeps them apart
  always_ff @(posedge sys_clk) begin
    if (strb_rise) begin
      shift_ff <= test_ff; // [RULE_07]
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[CHANNELS-2:0], sync_ff[0]}; // [RULE_02] [RULE_03]
    end
  end

  // Parallel transfer into the latch, never reset
  always_ff @(posedge sys_clk) begin
    if (strb_rise) begin
      latch_ff <= shift_ff; // [RULE_06] [RULE_01] [RULE_11]
    end
  end

  // Serial output moves only with a shift edge and takes bit 14, so the next part sees the new MSB
  always_ff @(posedge sys_clk) begin
    if (sclk_rise) begin
      sdo_ff <= shift_ff[CHANNELS-2]; // [RULE_04] [RULE_05]
    end
  end
  assign link.serial_data_out = sdo_ff;

  // ==========================================================================
  // Output stage: one flop per channel, all loaded on the same edge
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_out
      always_ff @(posedge sys_clk) begin
        sink_output_n[ch] <= latch_ff[ch] && !sync_ff[3]; // [RULE_09] [RULE_10] [RULE_15] [RULE_16]
      end
    end
  endgenerate

  // Latch copy for observation
  always_ff @(posedge sys_clk) begin
    latch_view <= latch_ff;
  end
endmodule
`default_nettype wire

// File: lss_host.sv
// Controller end: takes 16-bit frames from a FIFO, shifts them out MSB first,
// strobes the latch once per frame and drives blanking.
// Assumes one sys_clk; the serial return pin is foreign and synchronised.
`timescale 1ns/1ps
`default_nettype none
module lss_host
  import lss_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  lss_link_if.host                  link,
  input  wire logic [CHANNELS-1:0]  frame_data,
  input  wire logic                 frame_valid,
  output logic                      frame_ready,
  input  wire logic                 blank_req,
  output logic                      busy,
  output logic                      loaded,
  output logic                      chain_bit
);
  // ==========================================================================
  // Frame buffer
  logic [CHANNELS-1:0] fifo_data;
  logic                fifo_valid;
  logic                fifo_pop;
  lss_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_data   (frame_data),
    .in_valid  (frame_valid),
    .in_ready  (frame_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ==========================================================================
  // Sequencer
  lss_host_state_t     state_ff;
  logic [CHANNELS-1:0] sh_ff;
  logic [4:0]          bits_ff;
  logic [7:0]          tick_ff;
  logic                sclk_ff;
  logic                sdi_ff;
  logic                strb_ff;
  logic                blank_ff;
  logic                loaded_ff;
  logic                tick_done;

  assign tick_done = (state_ff == HS_GAP) ? (tick_ff == GAP_LAST) : (tick_ff == HALF_LAST);
  assign fifo_pop  = (state_ff == HS_IDLE) && fifo_valid;

  // Half-period divider, restarted on each state change
  always_ff @(posedge sys_clk) begin
    if (rst || state_ff == HS_IDLE || tick_done) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= tick_ff + 8'h01;
    end
  end

  // Shift clock and data; data set up a half period ahead of each rise
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= HS_IDLE;
      sh_ff    <= '0;
      bits_ff  <= '0;
      sclk_ff  <= 1'b0;
      sdi_ff   <= 1'b0;
      strb_ff  <= 1'b0;
    end else begin
      case (state_ff)
        HS_IDLE: begin
          if (fifo_valid) begin
            sh_ff    <= {fifo_data[CHANNELS-2:0], 1'b0};
            sdi_ff   <= fifo_data[CHANNELS-1];
            bits_ff  <= 5'h10;
            state_ff <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick_done) begin
            sclk_ff  <= 1'b1;
            bits_ff  <= bits_ff - 5'h01;
            state_ff <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tick_done) begin
            sclk_ff <= 1'b0;
            if (bits_ff == 5'h00) begin
              state_ff <= HS_STROBE;
            end else begin
              sdi_ff   <= sh_ff[CHANNELS-1];
              sh_ff    <= {sh_ff[CHANNELS-2:0], 1'b0};
              state_ff <= HS_LOW;
            end
          end
        end
        HS_STROBE: begin
          strb_ff <= 1'b1; // Exactly one strobe per full frame [RULE_08]
          if (tick_done) begin
            state_ff <= HS_GAP;
          end
        end
        HS_GAP: begin
          strb_ff <= 1'b0; // Gap keeps the next shift edge clear of the strobe
          if (tick_done) begin
            state_ff <= HS_IDLE;
          end
        end
        default: state_ff <= HS_IDLE;
      endcase
    end
  end

  // Blanking held high from reset until a frame is latched [RULE_12] [RULE_13]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      loaded_ff <= 1'b0;
    end else if (state_ff == HS_GAP && tick_done) begin
      loaded_ff <= 1'b1;
    end
  end

  // Unused channels are the user's to zero in frame_data [RULE_14]
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blank_ff <= 1'b1;
    end else begin
      blank_ff <= blank_req || !loaded_ff;
    end
  end

  // Status and return-pin synchroniser
  logic ret_meta_ff;
  logic ret_sync_ff;
  always_ff @(posedge sys_clk) begin
    ret_meta_ff <= link.serial_data_out;
    ret_sync_ff <= ret_meta_ff;
    busy        <= (state_ff != HS_IDLE) && !rst;
    loaded      <= loaded_ff && !rst;
    chain_bit   <= ret_sync_ff && !rst;
  end

  assign link.serial_data_in = sdi_ff;
  assign link.shift_clk      = sclk_ff;
  assign link.latch_strobe   = strb_ff;
  assign link.blank          = blank_ff;
endmodule
`default_nettype wire

// File: lss_props.sv
// Checker for the LED sink link: link pins and the device outputs.
// Assumes every pin is a sys_clk flop; the bench instantiates it, no bind.
`timescale 1ns/1ps
`default_nettype none
module lss_props
  import lss_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        serial_data_in,
  input wire logic        shift_clk,
  input wire logic        latch_strobe,
  input wire logic        blank,
  input wire logic        serial_data_out,
  input wire logic [15:0] sink_output_n,
  input wire logic [15:0] latch_view
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Helper logic
  logic        sclk_q_ff, strb_q_ff, done_ff;
  logic [5:0]  sh_ff, lh_ff;
  logic [15:0] mdl_ff, snap_ff;
  logic [4:0]  cnt_ff, gap_ff;
  wire sr = shift_clk & ~sclk_q_ff;
  wire lr = latch_strobe & ~strb_q_ff;
  // Edge history, so device latency can be judged after the event
  always_ff @(posedge sys_clk) begin
    sclk_q_ff <= shift_clk;
    strb_q_ff <= latch_strobe;
    sh_ff     <= {sh_ff[4:0], sr};
    lh_ff     <= {lh_ff[4:0], lr};
  end
  // Reference shift register; no reset, like the device itself
  always_ff @(posedge sys_clk) begin
    if (sr) mdl_ff <= {mdl_ff[14:0], serial_data_in};
    if (lr) snap_ff <= mdl_ff;
  end
  // Shift count per frame, cycles since strobe, first strobe seen
  always_ff @(posedge sys_clk) begin
    if (rst || lr) cnt_ff <= 5'h00;
    else if (sr && cnt_ff != 5'h1f) cnt_ff <= cnt_ff + 5'h01;
    if (rst) gap_ff <= 5'h1f;
    else if (lr) gap_ff <= 5'h00;
    else if (gap_ff != 5'h1f) gap_ff <= gap_ff + 5'h01;
    if (rst) done_ff <= 1'b0;
    else if (lr) done_ff <= 1'b1;
  end
  // ==========================================================================
  // Assertions
  shift_msb_a: assert property (
    sh_ff[5] && cnt_ff >= 5'h10 |-> serial_data_out == mdl_ff[15])
    else $error("serial output is not the shifted-in bit");
  out_edge_a: assert property (
    $changed(serial_data_out) |-> (|{sh_ff[4:0], sr, lh_ff[4:0], lr}))
    else $error("serial output moved without a shift edge");
  latch_copy_a: assert property (
    lh_ff[5] |-> latch_view == snap_ff) else $error("latch does not hold register");
  blank_off_a: assert property (
    blank [*5] |-> sink_output_n == 16'h0000) else $error("sink on while blanked");
  show_latch_a: assert property (
    (!blank && $stable(latch_view)) [*5] |-> sink_output_n == latch_view)
    else $error("sinks differ from latch");
  one_latch_a: assert property (
    lr |-> cnt_ff == 5'h10) else $error("strobe not after exactly sixteen shifts");
  strobe_gap_a: assert property (
    sr |-> gap_ff >= 5'h14) else $error("shift edge too soon after strobe");
  boot_blank_a: assert property (
    !done_ff |-> blank) else $error("blanking released before first latch");
  cover property (lr);
  cover property (blank ##1 !blank);
  cover property (sh_ff[5] && cnt_ff >= 5'h10);
endmodule
`default_nettype wire

// File: lss_test.sv
// Bench: host and device joined by the link interface, driven by frames.
// Assumes the 200 MHz clock; the host makes the link clock itself.
`timescale 1ns/1ps
`default_nettype none
module lss_test
  import lss_pkg::*;
;
  logic        sys_clk, rst, frame_valid, frame_ready, blank_req, busy, loaded, refused, chain_bit;
  logic [15:0] frame_data, sink_output_n, latch_view;
  int          failures, checked;
  logic [15:0] pat [6] = '{16'h8000, 16'ha5c3, 16'h0ff0, 16'hffff, 16'h1234, 16'hc001};
  lss_link_if i_lss_link_if ();
  lss_host i_lss_host (.sys_clk(sys_clk), .rst(rst), .link(i_lss_link_if.host),
    .frame_data(frame_data), .frame_valid(frame_valid), .frame_ready(frame_ready),
    .blank_req(blank_req), .busy(busy), .loaded(loaded), .chain_bit(chain_bit));
  lss_device i_lss_device (.sys_clk(sys_clk), .rst(rst), .link(i_lss_link_if.dev),
    .sink_output_n(sink_output_n), .latch_view(latch_view));
  lss_props i_lss_props (.sys_clk(sys_clk), .rst(rst),
    .serial_data_in(i_lss_link_if.serial_data_in), .shift_clk(i_lss_link_if.shift_clk),
    .latch_strobe(i_lss_link_if.latch_strobe), .blank(i_lss_link_if.blank),
    .serial_data_out(i_lss_link_if.serial_data_out),
    .sink_output_n(sink_output_n), .latch_view(latch_view));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Inputs always move 1 ns after the edge
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Valid stays up between calls so back-to-back frames need no gap
  task automatic send(input logic [15:0] d);
    int n;
    frame_data = d;
    frame_valid = 1'b1;
    refused = 1'b0;
    for (n = 0; n < 3000 && frame_ready !== 1'b1; n++) begin
      refused = 1'b1;
      cycles(1);
    end
    if (frame_ready !== 1'b1) begin
      failures++;
      complete_run();
    end
    cycles(1);
  endtask
  // Busy may dip between frames, so idle means eight quiet cycles
  task automatic drain();
    int n, q;
    q = 0;
    for (n = 0; n < 4000 && q < 8; n++) begin
      q = (busy === 1'b0) ? q + 1 : 0;
      cycles(1);
    end
    if (q < 8) begin
      failures++;
      complete_run();
    end
  endtask
  // ==========================================================================
  // Tests
  initial begin
    rst = 1'b1;
    frame_valid = 1'b0;
    frame_data = 16'h0000;
    blank_req = 1'b0;
    failures = 0;
    checked = 0;
    cycles(8);
    rst = 1'b0;
    cycles(10);
    chk("boot blank", 16'h0001, {15'h0000, i_lss_link_if.blank});
    chk("boot sinks", 16'h0000, sink_output_n);
    chk("boot loaded", 16'h0000, {15'h0000, loaded});
    $display("Test boot done");
    send(16'h0001);
    frame_valid = 1'b0;
    drain();
    chk("first latch", 16'h0001, latch_view);
    chk("first sinks", 16'h0001, sink_output_n);
    chk("first loaded", 16'h0001, {15'h0000, loaded});
    chk("first chain", 16'h0000, {15'h0000, chain_bit});
    $display("Test first frame done");
    // Four queued plus one shifting, so the sixth frame must wait
    foreach (pat[i]) begin
      send(pat[i]);
    end
    frame_valid = 1'b0;
    chk("queue refusal", 16'h0001, {15'h0000, refused});
    drain();
    chk("last latch", pat[5], latch_view);
    chk("last sinks", pat[5], sink_output_n);
    chk("last chain", 16'h0001, {15'h0000, chain_bit});
    $display("Test queue done");
    blank_req = 1'b1;
    cycles(10);
    chk("blank sinks", 16'h0000, sink_output_n);
    blank_req = 1'b0;
    cycles(10);
    chk("unblank sinks", pat[5], sink_output_n);
    $display("Test blanking done");
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
